/* src/scan_win_pkg.sv */
// constants, byte map and types for the scan window parameter decoder
package scan_win_pkg;

  // list shape
  localparam int MAX_WIN  = 99;
  localparam int HDR_LEN  = 8;
  localparam int DESC_LEN = 40;
  localparam logic [15:0] DESC_LEN_CODE = 16'h0028;
  localparam int HDR_LEN_MSB_OFS = 6;
  localparam int HDR_LEN_LSB_OFS = 7;

  // descriptor byte map
  localparam int OFS_ID     = 0;
  localparam int OFS_RSV1   = 1;
  localparam int OFS_XRES   = 2;
  localparam int OFS_YRES   = 4;
  localparam int OFS_ULX    = 6;
  localparam int OFS_ULY    = 10;
  localparam int OFS_WIDTH  = 14;
  localparam int OFS_LENGTH = 18;
  localparam int OFS_BRIGHT = 22;
  localparam int OFS_THRESH = 23;
  localparam int OFS_CONTR  = 24;
  localparam int OFS_COMP   = 25;
  localparam int OFS_DEPTH  = 26;
  localparam int OFS_HTONE  = 27;
  localparam int OFS_PAD    = 29;
  localparam int OFS_RSV30  = 30;
  localparam int OFS_RSV31  = 31;
  localparam int OFS_CMPR   = 32;
  localparam int OFS_RSV_LO = 33;
  localparam int OFS_RSV_HI = 39;
  localparam int PAD_W      = 2;

  // defaults substituted for zero fields
  localparam logic [15:0] RES_DEF    = 16'h004B;
  localparam logic [31:0] ULX_DEF    = 32'h00000000;
  localparam logic [31:0] ULY_DEF    = 32'h00000000;
  localparam logic [31:0] WIDTH_DEF  = 32'h000027E0;
  localparam logic [31:0] LENGTH_DEF = 32'h00003390;
  localparam logic [7:0]  BRIGHT_DEF = 8'h80;
  localparam logic [7:0]  THRESH_DEF = 8'h80;
  localparam logic [7:0]  CONTR_DEF  = 8'h01;

  // codes
  localparam logic [7:0]  COMP_LINE  = 8'h00;
  localparam logic [7:0]  COMP_HALF  = 8'h01;
  localparam logic [7:0]  COMP_GRAY  = 8'h02;
  localparam logic [15:0] HT_SPIRAL  = 16'h0000;
  localparam logic [15:0] HT_BAYER   = 16'h0001;
  localparam logic [15:0] HT_LOADED  = 16'h0002;
  localparam logic [PAD_W-1:0] PAD_TRUNC = 2'h3;
  localparam logic [7:0]  CMPR_NONE  = 8'h00;
  localparam logic [7:0]  CMPR_G3    = 8'h01;
  localparam logic [7:0]  CMPR_WLS   = 8'h83;
  localparam logic [3:0]  DEPTH_GRAY = 4'h4;
  localparam logic [3:0]  DEPTH_BW   = 4'h1;

  // accepted resolutions
  localparam int RES_ALL_N  = 18;
  localparam int RES_GRAY_N = 5;
  localparam logic [15:0] RES_105 = 16'h0069;
  localparam logic [RES_ALL_N-1:0][15:0] RES_ALL = {
    16'h012C, 16'h011D, 16'h010E, 16'h00FF, 16'h00F0, 16'h00E1,
    16'h00D2, 16'h00C8, 16'h00C3, 16'h00B4, 16'h00A5, 16'h0096,
    16'h0087, 16'h0078, 16'h0069, 16'h0064, 16'h005A, 16'h004B};
  localparam logic [RES_GRAY_N-1:0][15:0] RES_GRAY = {
    16'h012C, 16'h00C8, 16'h0096, 16'h0064, 16'h004B};

  // error flag bits
  localparam int ERR_W     = 7;
  localparam int ERR_HDR   = 0;
  localparam int ERR_XFER  = 1;
  localparam int ERR_COUNT = 2;
  localparam int ERR_DUP   = 3;
  localparam int ERR_RES   = 4;
  localparam int ERR_CODE  = 5;
  localparam int ERR_RSV   = 6;

  typedef struct packed {
    logic [7:0]  id;
    logic [15:0] xres;
    logic [15:0] yres;
    logic [31:0] ulx;
    logic [31:0] uly;
    logic [31:0] width;
    logic [31:0] length;
    logic [7:0]  bright;
    logic [7:0]  thresh;
    logic        auto_bg;
    logic [7:0]  contrast;
    logic [7:0]  comp;
    logic [3:0]  depth;
    logic [15:0] htone;
    logic        pad_trunc;
    logic [7:0]  cmpr;
  } win_s;

endpackage

/* src/res_check_if.sv */
// resolution check request and answer between decoder and checker
`timescale 1ns/1ns
interface res_check_if;
  logic [15:0] res;
  logic        gray;
  logic        ok;
  modport judge (input res, input gray, output ok);
  modport user (output res, output gray, input ok);
endinterface

/* src/res_checker.sv */
// checks one resolution value against the accepted set for the mode
`timescale 1ns/1ns
module res_checker
  import scan_win_pkg::*;
#(
  parameter bit ALLOW_105 = 1'b1
) (
  res_check_if.judge chk
);

  always_comb begin
    chk.ok = 1'b0;
    if (chk.gray) begin
      for (int i = 0; i < RES_GRAY_N; i++) begin
        if (chk.res == RES_GRAY[i]) begin
          chk.ok = 1'b1;
        end
      end
    end else begin
      for (int i = 0; i < RES_ALL_N; i++) begin
        if (chk.res == RES_ALL[i] && (ALLOW_105 || RES_ALL[i] != RES_105)) begin
          chk.ok = 1'b1;
        end
      end
    end
  end

endmodule

/* src/field_default.sv */
// substitutes a default for a zero field value
`timescale 1ns/1ns
module field_default #(
  parameter int           W   = 8,
  parameter logic [W-1:0] DEF = '0
) (
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] val
);

  assign val = (raw == '0) ? DEF : raw;

endmodule

/* src/scan_window_param_decoder.sv */
// decoder and store for a scan window parameter list
`timescale 1ns/1ns
module scan_window_param_decoder
  import scan_win_pkg::*;
#(
  parameter int LEN_W = 24
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // command
  input  wire logic             start,
  input  wire logic [LEN_W-1:0] xfer_len,
  // parameter byte stream
  input  wire logic [7:0]       byte_data,
  input  wire logic             byte_valid,
  output logic                  byte_ready,
  // status
  output logic                  busy,
  output logic                  done,
  output logic [ERR_W-1:0]      err_flags,
  output logic [6:0]            win_count,
  // window lookup for the scan engine
  input  wire logic             lookup_req,
  input  wire logic [7:0]       lookup_id,
  output logic                  lookup_valid,
  output logic                  lookup_hit,
  output win_s                  lookup_win
);

  typedef enum {S_IDLE, S_HDR, S_DESC, S_COMMIT, S_FINISH} state_e;

  state_e           state_reg;
  logic [LEN_W-1:0] len_reg;
  logic [LEN_W-1:0] rx_cnt_reg;
  logic [5:0]       pos_reg;
  logic [6:0]       desc_cnt_reg;
  logic [15:0]      hdr_len_reg;
  logic [7:0]       buf_reg [DESC_LEN];
  logic [ERR_W-1:0] err_reg;
  logic [ERR_W-1:0] err_next;
  logic [255:0]     id_used_reg;
  logic [6:0]       slot_map [256];
  win_s             table_mem [MAX_WIN];
  logic [6:0]       count_reg;
  logic             ready_reg;
  logic             busy_reg;
  logic             done_reg;
  logic             valid_reg;
  logic             hit_reg;
  win_s             win_reg;
  logic take, last_byte, desc_end, gray, code_bad, rsv_bad, full, dup;
  win_s dec;
  res_check_if xchk ();
  res_check_if ychk ();

  assign take      = byte_valid && ready_reg;
  assign last_byte = take && (rx_cnt_reg == len_reg - LEN_W'(1));
  assign desc_end  = take && (pos_reg == 6'(DESC_LEN - 1));

  // field decode of the staged descriptor
  assign gray     = (buf_reg[OFS_COMP] == COMP_GRAY);
  assign xchk.res = dec.xres;
  assign xchk.gray = gray;
  assign ychk.res = dec.yres;
  assign ychk.gray = gray;

  res_checker #(.ALLOW_105(1'b1)) u_xres_chk (.chk(xchk));
  res_checker #(.ALLOW_105(1'b0)) u_yres_chk (.chk(ychk));

  field_default #(.W(16), .DEF(RES_DEF)) u_xres_def (
    .raw({buf_reg[OFS_XRES], buf_reg[OFS_XRES+1]}), .val(dec.xres));
  field_default #(.W(16), .DEF(RES_DEF)) u_yres_def (
    .raw({buf_reg[OFS_YRES], buf_reg[OFS_YRES+1]}), .val(dec.yres));
  field_default #(.W(32), .DEF(ULX_DEF)) u_ulx_def (
    .raw({buf_reg[OFS_ULX], buf_reg[OFS_ULX+1], buf_reg[OFS_ULX+2],
          buf_reg[OFS_ULX+3]}), .val(dec.ulx));
  field_default #(.W(32), .DEF(ULY_DEF)) u_uly_def (
    .raw({buf_reg[OFS_ULY], buf_reg[OFS_ULY+1], buf_reg[OFS_ULY+2],
          buf_reg[OFS_ULY+3]}), .val(dec.uly));
  field_default #(.W(32), .DEF(WIDTH_DEF)) u_width_def (
    .raw({buf_reg[OFS_WIDTH], buf_reg[OFS_WIDTH+1], buf_reg[OFS_WIDTH+2],
          buf_reg[OFS_WIDTH+3]}), .val(dec.width));
  field_default #(.W(32), .DEF(LENGTH_DEF)) u_length_def (
    .raw({buf_reg[OFS_LENGTH], buf_reg[OFS_LENGTH+1], buf_reg[OFS_LENGTH+2],
          buf_reg[OFS_LENGTH+3]}), .val(dec.length));
  field_default #(.W(8), .DEF(BRIGHT_DEF)) u_bright_def (
    .raw(buf_reg[OFS_BRIGHT]), .val(dec.bright));
  field_default #(.W(8), .DEF(THRESH_DEF)) u_thresh_def (
    .raw(buf_reg[OFS_THRESH]), .val(dec.thresh));
  field_default #(.W(8), .DEF(CONTR_DEF)) u_contr_def (
    .raw(buf_reg[OFS_CONTR]), .val(dec.contrast));

  assign dec.id        = buf_reg[OFS_ID];
  assign dec.comp      = buf_reg[OFS_COMP];
  // zero threshold only turns on auto background in line art
  assign dec.auto_bg   = (buf_reg[OFS_THRESH] == 8'h00) &&
                         (buf_reg[OFS_COMP] == COMP_LINE);
  // depth byte is ignored: depth follows the composition alone
  assign dec.depth     = gray ? DEPTH_GRAY : DEPTH_BW;
  // pattern only counts in halftone, so other modes store spiral
  assign dec.htone     = (buf_reg[OFS_COMP] == COMP_HALF) ?
                         {buf_reg[OFS_HTONE], buf_reg[OFS_HTONE+1]} :
                         HT_SPIRAL;
  assign dec.pad_trunc = (buf_reg[OFS_PAD][PAD_W-1:0] == PAD_TRUNC);
  assign dec.cmpr      = buf_reg[OFS_CMPR];
  assign code_bad = (buf_reg[OFS_COMP] > COMP_GRAY) ||
                    (buf_reg[OFS_COMP] == COMP_HALF &&
                     {buf_reg[OFS_HTONE], buf_reg[OFS_HTONE+1]} > HT_LOADED) ||
                    !dec.pad_trunc ||
                    (dec.cmpr != CMPR_NONE && dec.cmpr != CMPR_G3 &&
                     dec.cmpr != CMPR_WLS);

  // reserved bytes are checked so a sloppy host is reported, not trusted
  always_comb begin
    rsv_bad = (buf_reg[OFS_RSV1] != 8'h00) ||
              (buf_reg[OFS_PAD][7:PAD_W] != '0) ||
              (buf_reg[OFS_RSV30] != 8'h00) ||
              (buf_reg[OFS_RSV31] != 8'h00);
    for (int i = OFS_RSV_LO; i <= OFS_RSV_HI; i++) begin
      if (buf_reg[i] != 8'h00) begin
        rsv_bad = 1'b1;
      end
    end
  end

  assign full = (desc_cnt_reg >= 7'(MAX_WIN));
  assign dup  = id_used_reg[dec.id];

  // sequencing and stream back-pressure
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= S_IDLE;
      ready_reg <= 1'b0;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start) begin
            busy_reg <= 1'b1;
            if (xfer_len == '0) begin
              state_reg <= S_FINISH;
            end else begin
              state_reg <= S_HDR;
              ready_reg <= 1'b1;
            end
          end
        end
        S_HDR: begin
          if (last_byte) begin
            state_reg <= S_FINISH;
            ready_reg <= 1'b0;
          end else if (take && rx_cnt_reg == LEN_W'(HDR_LEN - 1)) begin
            state_reg <= S_DESC;
          end
        end
        S_DESC: begin
          // stall the stream one cycle while a descriptor is stored
          if (desc_end) begin
            state_reg <= S_COMMIT;
            ready_reg <= 1'b0;
          end else if (last_byte) begin
            state_reg <= S_FINISH;
            ready_reg <= 1'b0;
          end
        end
        S_COMMIT: begin
          if (rx_cnt_reg == len_reg) begin
            state_reg <= S_FINISH;
          end else begin
            state_reg <= S_DESC;
            ready_reg <= 1'b1;
          end
        end
        S_FINISH: begin
          state_reg <= S_IDLE;
          busy_reg  <= 1'b0;
          done_reg  <= 1'b1;
        end
        default: begin
          state_reg <= S_IDLE;
          ready_reg <= 1'b0;
        end
      endcase
    end
  end

  // byte counting and descriptor staging
  always_ff @(posedge clk) begin
    if (reset || (state_reg == S_IDLE && start)) begin
      len_reg      <= reset ? '0 : xfer_len;
      rx_cnt_reg   <= '0;
      pos_reg      <= '0;
      desc_cnt_reg <= '0;
      hdr_len_reg  <= '0;
    end else begin
      if (take) begin
        rx_cnt_reg <= rx_cnt_reg + LEN_W'(1);
      end
      if (take && state_reg == S_HDR) begin
        if (rx_cnt_reg == LEN_W'(HDR_LEN_MSB_OFS)) begin
          hdr_len_reg[15:8] <= byte_data;
        end
        if (rx_cnt_reg == LEN_W'(HDR_LEN_LSB_OFS)) begin
          hdr_len_reg[7:0] <= byte_data;
        end
      end
      if (take && state_reg == S_DESC) begin
        pos_reg <= desc_end ? 6'h00 : pos_reg + 6'h01;
      end
      if (state_reg == S_COMMIT && !full) begin
        desc_cnt_reg <= desc_cnt_reg + 7'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (take && state_reg == S_DESC) begin
      buf_reg[pos_reg] <= byte_data;
    end
  end

  // error flags, cleared by each new list
  always_comb begin
    err_next = err_reg;
    if (take && state_reg == S_HDR &&
        rx_cnt_reg < LEN_W'(HDR_LEN_MSB_OFS) && byte_data != 8'h00) begin
      err_next[ERR_HDR] = 1'b1;
    end
    if (state_reg == S_COMMIT) begin
      if (full) begin
        err_next[ERR_COUNT] = 1'b1;
      end else begin
        err_next[ERR_DUP]  = err_reg[ERR_DUP] | dup;
        err_next[ERR_RES]  = err_reg[ERR_RES] | !(xchk.ok && ychk.ok);
        err_next[ERR_CODE] = err_reg[ERR_CODE] | code_bad;
        err_next[ERR_RSV]  = err_reg[ERR_RSV] | rsv_bad;
      end
    end
    if (state_reg == S_FINISH && len_reg != '0) begin
      if (rx_cnt_reg < LEN_W'(HDR_LEN) || pos_reg != 6'h00) begin
        err_next[ERR_XFER] = 1'b1;
      end else if (desc_cnt_reg == 7'h00) begin
        err_next[ERR_COUNT] = 1'b1;
      end
      if (rx_cnt_reg >= LEN_W'(HDR_LEN) && hdr_len_reg != DESC_LEN_CODE) begin
        err_next[ERR_HDR] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset || (state_reg == S_IDLE && start)) begin
      err_reg <= '0;
    end else begin
      err_reg <= err_next;
    end
  end

  // window table; a list with any error leaves no window defined
  always_ff @(posedge clk) begin
    if (reset || (state_reg == S_IDLE && start)) begin
      id_used_reg <= '0;
      count_reg   <= '0;
    end else if (state_reg == S_COMMIT && !full && !dup) begin
      id_used_reg[dec.id] <= 1'b1;
    end else if (state_reg == S_FINISH) begin
      if (err_next == '0) begin
        count_reg <= desc_cnt_reg;
      end else begin
        id_used_reg <= '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (state_reg == S_COMMIT && !full && !dup) begin
      table_mem[desc_cnt_reg] <= dec;
      slot_map[dec.id]        <= desc_cnt_reg;
    end
  end

  // lookups while a list is loading miss, since the table is in flux
  always_ff @(posedge clk) begin
    if (reset) begin
      valid_reg <= 1'b0;
      hit_reg   <= 1'b0;
      win_reg   <= '0;
    end else begin
      valid_reg <= lookup_req;
      if (lookup_req) begin
        hit_reg <= !busy_reg && id_used_reg[lookup_id];
        win_reg <= (!busy_reg && id_used_reg[lookup_id]) ?
                   table_mem[slot_map[lookup_id]] : '0;
      end
    end
  end

  assign byte_ready   = ready_reg;
  assign busy         = busy_reg;
  assign done         = done_reg;
  assign err_flags    = err_reg;
  assign win_count    = count_reg;
  assign lookup_valid = valid_reg;
  assign lookup_hit   = hit_reg;
  assign lookup_win   = win_reg;

endmodule

/* testbench/scan_window_param_decoder_asserts.sv */
// port-level checks for the scan window parameter decoder
`timescale 1ns/1ns
module scan_window_param_decoder_asserts
  import scan_win_pkg::*;
#(
  parameter int LEN_W = 24
) (
  // clock and reset
  input wire logic             clk,
  input wire logic             reset,
  // command and stream
  input wire logic             start,
  input wire logic [LEN_W-1:0] xfer_len,
  input wire logic             byte_ready,
  // status
  input wire logic             busy,
  input wire logic             done,
  input wire logic [ERR_W-1:0] err_flags,
  input wire logic [6:0]       win_count,
  // lookup
  input wire logic             lookup_req,
  input wire logic             lookup_valid,
  input wire logic             lookup_hit,
  input wire win_s             lookup_win
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence start_idle_s; start && !busy; endsequence
  sequence hit_s; lookup_valid && lookup_hit; endsequence

  start_busy_a: assert property (start_idle_s |=> busy)
    else $error("busy did not follow start");
  empty_list_a: assert property ((start_idle_s and xfer_len == '0) |->
    ##2 (done && win_count == 7'h00 && err_flags == '0))
    else $error("empty list not finished cleanly");
  done_pulse_a: assert property (done |-> !busy ##1 !done)
    else $error("done not a single pulse after busy");
  busy_end_a: assert property ($fell(busy) && !$past(reset) |-> done)
    else $error("busy ended without done");
  idle_ready_a: assert property (!busy |-> !byte_ready)
    else $error("byte taken outside a list");
  bad_list_a: assert property (done && err_flags != '0 |->
    win_count == 7'h00)
    else $error("rejected list left windows");
  count_max_a: assert property (win_count <= 7'h63)
    else $error("more than the maximum windows");
  lookup_ans_a: assert property (lookup_req |=> lookup_valid)
    else $error("lookup not answered");
  valid_pulse_a: assert property (!lookup_req |=> !lookup_valid)
    else $error("answer without lookup");
  busy_miss_a: assert property (lookup_req && busy |=> !lookup_hit)
    else $error("hit while loading");
  miss_zero_a: assert property (lookup_valid && !lookup_hit |->
    lookup_win == '0)
    else $error("miss returned data");
  depth_mode_a: assert property (hit_s |-> lookup_win.depth ==
    ((lookup_win.comp == COMP_GRAY) ? DEPTH_GRAY : DEPTH_BW))
    else $error("pixel depth wrong for mode");
  htone_mode_a: assert property ((hit_s and lookup_win.comp != COMP_HALF)
    |-> lookup_win.htone == HT_SPIRAL)
    else $error("pattern kept outside halftone");
  auto_bg_a: assert property ((hit_s and lookup_win.auto_bg) |->
    lookup_win.comp == COMP_LINE && lookup_win.thresh == 8'h80)
    else $error("auto background outside line art");
  zero_dflt_a: assert property (hit_s |-> lookup_win.bright != 8'h00
    && lookup_win.contrast != 8'h00 && lookup_win.pad_trunc)
    else $error("zero field kept without default");
endmodule

bind scan_window_param_decoder scan_window_param_decoder_asserts #(
  .LEN_W(LEN_W)
) u_asserts (
  .clk(clk), .reset(reset), .start(start), .xfer_len(xfer_len),
  .byte_ready(byte_ready), .busy(busy), .done(done),
  .err_flags(err_flags), .win_count(win_count),
  .lookup_req(lookup_req), .lookup_valid(lookup_valid),
  .lookup_hit(lookup_hit), .lookup_win(lookup_win)
);

/* testbench/host_model.sv */
// host side that streams a parameter list into the decoder
`timescale 1ns/1ns
module host_model (
  // clock
  input  wire logic       clk,
  // byte stream
  input  wire logic       byte_ready,
  output logic      [7:0] byte_data,
  output logic            byte_valid
);
  initial begin
    byte_data = 8'h00;
    byte_valid = 1'b0;
  end

  // entered at a falling edge; a byte is held until the decoder takes it
  task automatic send(input byte unsigned q[$], output bit ok);
    int n;
    ok = 1'b1;
    foreach (q[i]) begin
      byte_data = q[i];
      byte_valid = 1'b1;
      n = 0;
      while (byte_ready !== 1'b1 && n < 100) begin
        @(negedge clk);
        n++;
      end
      if (n == 100) ok = 1'b0;
      @(negedge clk);
    end
    byte_valid = 1'b0;
    // released bus: show a changed value so stale data cannot pass
    byte_data = ~byte_data;
  endtask
endmodule

/* testbench/scan_window_param_decoder_tb.sv */
// self-checking bench for the scan window parameter decoder
`timescale 1ns/1ns
`define check_eq(what, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("MISMATCH %s exp %0h got %0h", what, exp, got); \
    end \
  end
module scan_window_param_decoder_tb
  import scan_win_pkg::*;
();
  logic             clk, reset, start, byte_valid, byte_ready, busy, done;
  logic [23:0]      xfer_len;
  logic [7:0]       byte_data, lookup_id;
  logic [ERR_W-1:0] err_flags;
  logic [6:0]       win_count;
  logic             lookup_req, lookup_valid, lookup_hit;
  win_s             lookup_win;
  int               failures, total_checks, hdr0, hlen, nd, bo, bv, n;
  byte unsigned     q[$];
  win_s             model[int];
  int               base[14], r[14];
  int res_tab[18] = '{16'h012C, 16'h011D, 16'h010E, 16'h00FF, 16'h00F0,
    16'h00E1, 16'h00D2, 16'h00C8, 16'h00C3, 16'h00B4, 16'h00A5, 16'h0096,
    16'h0087, 16'h0078, 16'h0069, 16'h0064, 16'h005A, 16'h004B};
  int gray_tab[5] = '{16'h012C, 16'h00C8, 16'h0096, 16'h0064, 16'h004B};
  int cmpr_tab[3] = '{8'h00, 8'h01, 8'h83};
  int err_tab[15] = '{8'h01, 8'h01, 8'h02, 8'h08, 8'h10, 8'h10, 8'h20,
    8'h20, 8'h20, 8'h20, 8'h40, 8'h40, 8'h04, 8'h04, 8'h00};

  always #50 clk = ~clk;

  scan_window_param_decoder #(.LEN_W(24)) dut (
    .clk(clk), .reset(reset), .start(start), .xfer_len(xfer_len),
    .byte_data(byte_data), .byte_valid(byte_valid),
    .byte_ready(byte_ready), .busy(busy), .done(done),
    .err_flags(err_flags), .win_count(win_count),
    .lookup_req(lookup_req), .lookup_id(lookup_id),
    .lookup_valid(lookup_valid), .lookup_hit(lookup_hit),
    .lookup_win(lookup_win)
  );

  host_model host (
    .clk(clk), .byte_ready(byte_ready), .byte_data(byte_data),
    .byte_valid(byte_valid)
  );

  task automatic close_out;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // reference window: zero fields replaced by their defaults
  function automatic win_s expect_win(int r[14]);
    win_s w;
    w = '0;
    w.id = 8'(r[0]);
    w.xres = (r[1] == 0) ? 16'h004B : 16'(r[1]);
    w.yres = (r[2] == 0) ? 16'h004B : 16'(r[2]);
    w.ulx = 32'(r[3]);
    w.uly = 32'(r[4]);
    w.width = (r[5] == 0) ? 32'h000027E0 : 32'(r[5]);
    w.length = (r[6] == 0) ? 32'h00003390 : 32'(r[6]);
    w.bright = (r[7] == 0) ? 8'h80 : 8'(r[7]);
    w.thresh = (r[8] == 0) ? 8'h80 : 8'(r[8]);
    w.auto_bg = (r[8] == 0 && r[10] == 0);
    w.contrast = (r[9] == 0) ? 8'h01 : 8'(r[9]);
    w.comp = 8'(r[10]);
    w.depth = (r[10] == 2) ? 4'h4 : 4'h1;
    w.htone = (r[10] == 1) ? 16'(r[11]) : 16'h0000;
    w.pad_trunc = 1'b1;
    w.cmpr = 8'(r[13]);
    return w;
  endfunction

  task automatic put_hdr(int b0, int len);
    q.push_back(8'(b0));
    repeat (5) q.push_back(8'h00);
    q.push_back(8'(len >> 8));
    q.push_back(8'(len));
  endtask

  // byte map, most significant byte first; ofs >= 0 overrides one byte
  task automatic put_desc(int r[14], int ofs, int val);
    logic [319:0] v;
    v = {8'(r[0]), 8'h00, 16'(r[1]), 16'(r[2]), 32'(r[3]), 32'(r[4]),
      32'(r[5]), 32'(r[6]), 8'(r[7]), 8'(r[8]), 8'(r[9]), 8'(r[10]),
      ((r[10] == 2) ? 8'h04 : 8'h01), 16'(r[11]), 8'(r[12]), 16'h0000,
      8'(r[13]), 56'h0};
    if (ofs >= 0) v[319-8*ofs -: 8] = 8'(val);
    for (int i = 0; i < 40; i++) q.push_back(v[319-8*i -: 8]);
  endtask

  task automatic run_list(int nb, int exp_err, int exp_cnt);
    bit ok;
    int k;
    start = 1'b1;
    xfer_len = 24'(nb);
    @(negedge clk);
    start = 1'b0;
    host.send(q, ok);
    k = 0;
    while (done !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    if (!ok || k == 20) begin
      failures++;
      close_out();
    end
    `check_eq("err_flags", ERR_W'(exp_err), err_flags)
    `check_eq("win_count", 7'(exp_cnt), win_count)
    q = {};
    @(negedge clk);
  endtask

  task automatic look(int id, bit hit, win_s w);
    lookup_req = 1'b1;
    lookup_id = 8'(id);
    @(negedge clk);
    `check_eq("lookup_valid", 1'b1, lookup_valid)
    `check_eq("lookup_hit", hit, lookup_hit)
    `check_eq("lookup_win", w, lookup_win)
  endtask

  initial begin
    {clk, start, lookup_req, lookup_id, xfer_len} = '0;
    reset = 1'b1;
    failures = 0;
    total_checks = 0;
    void'($urandom(32'hFC5A6899));
    repeat (4) @(negedge clk);
    reset = 1'b0;
    `check_eq("idle", 19'h0, {byte_ready, busy, done, err_flags, win_count, lookup_valid, lookup_hit})
    // largest list: 99 windows covering every resolution and code
    base = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 3, 0};
    put_hdr(0, 40);
    for (int i = 0; i < 99; i++) begin
      r = base;
      if (i > 0) begin
        r[0] = (i == 98) ? 255 : i;
        r[10] = i % 2;
        r[1] = res_tab[i % 18];
        r[2] = (r[1] == 16'h0069) ? 0 : r[1];
        if (i % 4 == 3) begin
          r[10] = 2;
          r[1] = gray_tab[i % 5];
          r[2] = gray_tab[(i + 1) % 5];
        end
        r[3] = 8 * r[1] * (i % 4);
        r[5] = 8 * r[1] * (i % 5);
        r[4] = $urandom;
        r[6] = $urandom;
        r[7] = $urandom % 256;
        r[8] = $urandom % 256;
        r[9] = $urandom % 256;
        r[11] = i % 3;
        r[13] = cmpr_tab[i % 3];
      end
      model[r[0]] = expect_win(r);
      put_desc(r, -1, 0);
    end
    run_list(8 + 40 * 99, 0, 99);
    foreach (model[k]) look(k, 1'b1, model[k]);
    look(150, 1'b0, '0);
    lookup_req = 1'b0;
    // lists that break one thing each, then an empty list, each looked up shortly after start
    for (int e = 0; e < 15; e++) begin
      {hdr0, bv} = '0;
      {hlen, nd, bo} = {int'(40), int'(1), int'(-1)};
      r = base;
      r[0] = 9;
      case (e)
        0: hdr0 = 1;
        1: hlen = 41;
        3: nd = 2;
        4: {r[10], r[1]} = {int'(2), int'(285)};
        5: r[2] = 105;
        6: r[10] = 3;
        7: {r[10], r[11]} = {int'(1), int'(3)};
        8: r[12] = 2;
        9: r[13] = 2;
        10: {bo, bv} = {int'(35), int'(1)};
        11: {bo, bv} = {int'(29), int'(8'h43)};
        12: nd = 0;
        13: nd = 100;
        14: nd = -1;
        default: nd = 1;
      endcase
      if (nd >= 0) put_hdr(hdr0, hlen);
      for (int k = 0; k < nd; k++) begin
        if (e == 13) r[0] = k;
        put_desc(r, bo, bv);
      end
      if (e == 2) repeat (3) q.push_back(8'h00);
      n = q.size();
      fork
        run_list(n, err_tab[e], 0);
        begin
          repeat (3) @(negedge clk);
          look(0, 1'b0, '0);
          lookup_req = 1'b0;
        end
      join
    end
    close_out();
  end
endmodule
